// >>> core/bps_pkg.sv
package bps_pkg;
   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_NS      = 20;
   localparam int FRAME_NS    = 8333333;
   localparam int COLORS      = 3;
   localparam int SLOT_UNITS  = 256;
   localparam int UNIT_CYC    = FRAME_NS / (COLORS * SLOT_UNITS * CLK_NS);
   localparam int DUR_W       = 24;

   // ---------------------------------------------------------------
   // Pixel format
   // ---------------------------------------------------------------
   localparam int PIX_W       = 24;
   localparam int COLOR_W     = 8;
   localparam logic [1:0] BPP_16 = 2'h0;
   localparam logic [1:0] BPP_20 = 2'h1;
   localparam logic [1:0] BPP_24 = 2'h2;
   localparam logic [1:0] COLOR_LAST = 2'h2;

   // Display order of bit positions within a slot, entry 0 in low bits
   localparam logic [23:0] PLANE_ORDER = {3'h3, 3'h4, 3'h1, 3'h6, 3'h2, 3'h5, 3'h0, 3'h7};
   localparam logic [2:0]  ORD_LAST    = 3'h7;

   // ---------------------------------------------------------------
   // Sequencer states
   // ---------------------------------------------------------------
   typedef enum logic [4:0]
   {
      ST_IDLE  = 5'h01,
      ST_FLASH = 5'h02,
      ST_LOAD  = 5'h04,
      ST_HOLD  = 5'h08,
      ST_NEXT  = 5'h10
   } bps_state_e;
endpackage : bps_pkg

// >>> core/bps_sequencer.sv
`timescale 1ns/10ps
module bps_sequencer
   import bps_pkg::*;
#(
   parameter int H_PIX = 8,
   parameter int V_LIN = 4,
   parameter int UNIT  = UNIT_CYC
)
(
   input  wire logic                             CLK_SYS,
   input  wire logic                             RST_B,
   input  wire logic                             PCLK,
   input  wire logic                             VSYNC,
   input  wire logic                             DE,
   input  wire logic [PIX_W-1:0]                 PIX_A,
   input  wire logic [PIX_W-1:0]                 PIX_B,
   input  wire logic                             DUAL_PIX,
   input  wire logic [1:0]                       BPP_SEL,
   input  wire logic                             PAT_MODE,
   input  wire logic                             PAT_START,
   output      logic [$clog2(H_PIX*V_LIN)-1:0]   FL_ADDR,
   output      logic                             FL_RD_EN,
   input  wire logic [PIX_W-1:0]                 FL_RDATA,
   input  wire logic                             FL_RVALID,
   output      logic [H_PIX-1:0]                 MA_ROW_DATA,
   output      logic [$clog2(V_LIN)-1:0]         MA_ROW_ADDR,
   output      logic                             MA_ROW_WR,
   output      logic                             MA_PLANE_GO,
   output      logic [1:0]                       MA_COLOR,
   output      logic [2:0]                       MA_BIT,
   output      logic                             SEQ_BUSY
);
   localparam int NPIX  = H_PIX * V_LIN;
   localparam int PAW   = $clog2(NPIX);
   localparam int COL_W = $clog2(H_PIX);
   localparam int ROW_W = $clog2(V_LIN);

   // ---------------------------------------------------------------
   // Frame stores
   // ---------------------------------------------------------------
   logic [PIX_W-1:0] fmem [0:2*NPIX-1];
   logic [PIX_W-1:0] pmem [0:NPIX-1];

   // ---------------------------------------------------------------
   // Pixel clock domain
   // ---------------------------------------------------------------
   logic           prst_s1_r;
   logic           prst_s2_r;
   logic           prst_s3_r;
   logic           prst_ok;
   logic           vs_d_r;
   logic           wbank_r;
   logic [PAW:0]   wr_addr_r;

   always_ff @(posedge PCLK)
   begin
      prst_s1_r <= RST_B;
      prst_s2_r <= prst_s1_r;
      prst_s3_r <= prst_s2_r;
   end

   // Release counts once the last two stages are both high
   assign prst_ok = prst_s2_r && prst_s3_r;

   always_ff @(posedge PCLK)
   begin
      if (!prst_ok)
      begin
         vs_d_r    <= 1'b0;
         wbank_r   <= 1'b0;
         wr_addr_r <= '0;
      end
      else
      begin
         vs_d_r <= VSYNC;
         if (VSYNC && !vs_d_r)
         begin
            wr_addr_r <= '0;
            wbank_r   <= ~wbank_r;
         end
         else if (DE && wr_addr_r < (PAW+1)'(NPIX))
            wr_addr_r <= wr_addr_r + (DUAL_PIX ? (PAW+1)'(2) : (PAW+1)'(1));
      end
   end

   always_ff @(posedge PCLK)
   begin
      if (prst_ok && DE && wr_addr_r < (PAW+1)'(NPIX))
      begin
         fmem[{wbank_r, wr_addr_r[PAW-1:0]}] <= PIX_A;
         if (DUAL_PIX && wr_addr_r < (PAW+1)'(NPIX-1))
            fmem[{wbank_r, wr_addr_r[PAW-1:0] + PAW'(1)}] <= PIX_B;
      end
   end

   // ---------------------------------------------------------------
   // Frame-done crossing
   // ---------------------------------------------------------------
   logic tg_s1_r;
   logic tg_s2_r;
   logic tg_s3_r;
   logic tg_acc_r;
   logic frame_evt;

   always_ff @(posedge CLK_SYS)
   begin
      if (!RST_B)
      begin
         tg_s1_r  <= 1'b0;
         tg_s2_r  <= 1'b0;
         tg_s3_r  <= 1'b0;
         tg_acc_r <= 1'b0;
      end
      else
      begin
         tg_s1_r <= wbank_r;
         tg_s2_r <= tg_s1_r;
         tg_s3_r <= tg_s2_r;
         if (frame_evt)
            tg_acc_r <= tg_s3_r;
      end
   end

   // Blanking gives the planes time to finish before a bank is reused
   assign frame_evt = (tg_s2_r == tg_s3_r) && (tg_s3_r != tg_acc_r);

   // Only these two events override the sequencer; the row in flight is dropped
   logic restart;
   assign restart = (PAT_MODE && PAT_START) || (frame_evt && !PAT_MODE);

   // ---------------------------------------------------------------
   // Sequencer
   // ---------------------------------------------------------------
   bps_state_e        state_r;
   logic [1:0]        color_r;
   logic [2:0]        ord_r;
   logic [ROW_W-1:0]  row_r;
   logic [DUR_W-1:0]  dur_r;
   logic              bank_r;
   logic [PAW:0]      req_r;
   logic [PAW-1:0]    fl_cnt_r;
   logic [2:0]        bitpos;
   logic [3:0]        depth;
   logic              used;
   logic [4:0]        bit_idx;
   logic [H_PIX-1:0]  row_bits;

   function automatic logic [3:0] color_depth(input logic [1:0] bpp, input logic [1:0] c);
      if (bpp == BPP_16)
         color_depth = (c == 2'h1) ? 4'h6 : 4'h5;
      else if (bpp == BPP_20)
         color_depth = (c == COLOR_LAST) ? 4'h6 : 4'h7;
      else
         color_depth = 4'h8;
   endfunction : color_depth

   assign bitpos  = PLANE_ORDER[ord_r*3 +: 3];
   assign depth   = color_depth(BPP_SEL, color_r);
   assign used    = ({1'b0, bitpos} + depth) >= 4'h8;
   assign bit_idx = 5'((COLOR_LAST - color_r) * COLOR_W) + 5'(bitpos);

   generate
      for (genvar j = 0; j < H_PIX; j++)
      begin : g_col
         logic [PAW-1:0] a;
         assign a = {row_r, COL_W'(j)};
         assign row_bits[j] = PAT_MODE ? pmem[a][bit_idx] : fmem[{bank_r, a}][bit_idx];
      end
   endgenerate

   always_ff @(posedge CLK_SYS)
   begin
      if (!RST_B)
      begin
         state_r  <= ST_IDLE;
         color_r  <= 2'h0;
         ord_r    <= 3'h0;
         row_r    <= '0;
         dur_r    <= '0;
         bank_r   <= 1'b0;
         req_r    <= '0;
         fl_cnt_r <= '0;
      end
      else if (PAT_MODE && PAT_START)
      begin
         state_r  <= ST_FLASH;
         req_r    <= '0;
         fl_cnt_r <= '0;
      end
      else if (frame_evt && !PAT_MODE)
      begin
         state_r <= ST_LOAD;
         color_r <= 2'h0;
         ord_r   <= 3'h0;
         row_r   <= '0;
         bank_r  <= ~tg_s3_r;
      end
      else
      begin
         case (state_r)
            ST_FLASH:
            begin
               if (FL_RD_EN)
                  req_r <= req_r + (PAW+1)'(1);
               if (FL_RVALID)
               begin
                  fl_cnt_r <= fl_cnt_r + PAW'(1);
                  if (fl_cnt_r == PAW'(NPIX-1))
                  begin
                     state_r <= ST_LOAD;
                     color_r <= 2'h0;
                     ord_r   <= 3'h0;
                     row_r   <= '0;
                  end
               end
            end
            ST_LOAD:
            begin
               if (!used)
                  state_r <= ST_NEXT;
               else if (row_r == ROW_W'(V_LIN-1))
               begin
                  state_r <= ST_HOLD;
                  row_r   <= '0;
                  dur_r   <= DUR_W'(UNIT) << bitpos;
               end
               else
                  row_r <= row_r + ROW_W'(1);
            end
            ST_HOLD:
            begin
               dur_r <= dur_r - DUR_W'(1);
               if (dur_r == DUR_W'(1))
                  state_r <= ST_NEXT;
            end
            ST_NEXT:
            begin
               ord_r <= ord_r + 3'h1;
               if (ord_r != ORD_LAST)
                  state_r <= ST_LOAD;
               else if (color_r != COLOR_LAST)
               begin
                  color_r <= color_r + 2'h1;
                  state_r <= ST_LOAD;
               end
               else
               begin
                  color_r <= 2'h0;
                  state_r <= PAT_MODE ? ST_LOAD : ST_IDLE;
               end
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge CLK_SYS)
   begin
      if (state_r == ST_FLASH && FL_RVALID)
         pmem[fl_cnt_r] <= FL_RDATA;
   end

   assign FL_RD_EN = (state_r == ST_FLASH) && (req_r < (PAW+1)'(NPIX));
   assign FL_ADDR  = req_r[PAW-1:0];
   assign SEQ_BUSY = (state_r != ST_IDLE);

   // ---------------------------------------------------------------
   // Mirror array outputs
   // ---------------------------------------------------------------
   always_ff @(posedge CLK_SYS)
   begin
      if (!RST_B)
      begin
         MA_ROW_DATA <= '0;
         MA_ROW_ADDR <= '0;
         MA_ROW_WR   <= 1'b0;
         MA_PLANE_GO <= 1'b0;
         MA_COLOR    <= 2'h0;
         MA_BIT      <= 3'h0;
      end
      else
      begin
         MA_ROW_WR   <= (state_r == ST_LOAD) && used && !restart;
         MA_ROW_DATA <= row_bits;
         MA_ROW_ADDR <= row_r;
         MA_PLANE_GO <= (state_r == ST_LOAD) && used && (row_r == ROW_W'(V_LIN-1))
                        && !restart;
         MA_COLOR    <= color_r;
         MA_BIT      <= bitpos;
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   logic [DUR_W-1:0] hold_cnt_r;

   always_ff @(posedge CLK_SYS)
   begin
      if (!RST_B || state_r != ST_HOLD)
         hold_cnt_r <= '0;
      else
         hold_cnt_r <= hold_cnt_r + DUR_W'(1);
   end

   sequence s_rows;
      (MA_ROW_WR && !MA_PLANE_GO) [*3] ##1 (MA_ROW_WR && MA_PLANE_GO);
   endsequence

   sequence s_flash_go;
      (state_r == ST_FLASH) ##0 FL_RD_EN ##1 (state_r == ST_FLASH);
   endsequence

   property p_restart;
      @(posedge CLK_SYS) disable iff (!RST_B)
      frame_evt && !PAT_MODE && !PAT_START |=> state_r == ST_LOAD && color_r == 2'h0 && ord_r == 3'h0;
   endproperty
   a_restart: assert property (p_restart) else $error("frame did not restart plane sequence");

   property p_rows;
      @(posedge CLK_SYS) disable iff (!RST_B || restart)
      $rose(MA_ROW_WR) && !frame_evt && !PAT_START |-> s_rows;
   endproperty
   a_rows: assert property (p_rows) else $error("plane not loaded row by row before go");

   property p_dur;
      @(posedge CLK_SYS) disable iff (!RST_B)
      state_r == ST_NEXT && $past(state_r == ST_HOLD) |->
         $past(hold_cnt_r) == (DUR_W'(UNIT) << MA_BIT) - DUR_W'(1);
   endproperty
   a_dur: assert property (p_dur) else $error("plane hold time not binary weighted");

   property p_used;
      @(posedge CLK_SYS) disable iff (!RST_B)
      MA_PLANE_GO |-> ({1'b0, MA_BIT} + color_depth(BPP_SEL, MA_COLOR)) >= 4'h8;
   endproperty
   a_used: assert property (p_used) else $error("plane shown beyond color depth");

   property p_color_step;
      @(posedge CLK_SYS) disable iff (!RST_B)
      state_r == ST_NEXT && ord_r == ORD_LAST && color_r != COLOR_LAST && !frame_evt && !PAT_START
         |=> color_r == $past(color_r) + 2'h1;
   endproperty
   a_color_step: assert property (p_color_step) else $error("color slot did not advance");

   property p_shuffle;
      @(posedge CLK_SYS) disable iff (!RST_B || restart)
      $rose(MA_ROW_WR) |-> ##3 MA_PLANE_GO && MA_BIT == $past(bitpos, 4);
   endproperty
   a_shuffle: assert property (p_shuffle) else $error("plane order differs from order table");

   property p_flash_start;
      @(posedge CLK_SYS) disable iff (!RST_B)
      PAT_MODE && PAT_START |=> s_flash_go;
   endproperty
   a_flash_start: assert property (p_flash_start) else $error("flash load did not start");

   property p_flash_done;
      @(posedge CLK_SYS) disable iff (!RST_B)
      state_r == ST_FLASH && FL_RVALID && fl_cnt_r == PAW'(NPIX-1) && !PAT_START
         |=> state_r == ST_LOAD ##1 MA_ROW_WR || state_r == ST_NEXT;
   endproperty
   a_flash_done: assert property (p_flash_done) else $error("display did not follow flash load");

   property p_dual;
      @(posedge PCLK) disable iff (!prst_ok)
      DE && DUAL_PIX && !(VSYNC && !vs_d_r) && wr_addr_r < (PAW+1)'(NPIX)
         |=> wr_addr_r == $past(wr_addr_r) + (PAW+1)'(2);
   endproperty
   a_dual: assert property (p_dual) else $error("two pixels per clock not stored");
endmodule : bps_sequencer

// >>> test/bps_partner.sv
`timescale 1ns/10ps
module bps_partner
   import bps_pkg::*;
#(
   parameter int H = 8
)
(
   input  wire logic             CLK_SYS,
   input  wire logic             PCLK,
   output      logic             VSYNC,
   output      logic             DE,
   output      logic [PIX_W-1:0] PIX_A,
   output      logic [PIX_W-1:0] PIX_B,
   input  wire logic [4:0]       FL_ADDR,
   input  wire logic             FL_RD_EN,
   output      logic [PIX_W-1:0] FL_RDATA,
   output      logic             FL_RVALID
);
   logic [PIX_W-1:0] img  [0:63];
   logic [PIX_W-1:0] fmem [0:31];
   logic [PIX_W:0]   pipe [0:3];
   logic [PIX_W-1:0] cnt;
   int               slow;
   // 370 us back porch counted in 48 ns pixel clocks, rounded up
   localparam int    VBP_PCLK = 7709;

   // ----------------------------------------
   // Video source
   // ----------------------------------------
   initial
   begin
      VSYNC = 1'b0;
      DE    = 1'b0;
      PIX_A = 24'h0;
      PIX_B = 24'h0;
      cnt   = 24'h0;
      slow  = 0;
      for (int i = 0; i < 4; i++)
         pipe[i] = 25'h0;
   end

   task automatic blank(input int m);
      repeat (m)
      begin
         @(posedge PCLK);
         #2;
         DE    = 1'b0;
         PIX_A = ~PIX_A;
         PIX_B = ~PIX_B;
      end
   endtask : blank

   // Minimum blanking: 80 pixels after each line, one line before and the back porch after sync
   task automatic send_frame(input int n, input bit dual);
      int st;
      st = dual ? 2 : 1;
      for (int i = 0; i < n; i = i + st)
      begin
         @(posedge PCLK);
         #2;
         DE    = 1'b1;
         PIX_A = img[i];
         PIX_B = img[i+1];
         if ((i + st) % H == 0)
            blank(80);
      end
      blank(H + 80);
      VSYNC = 1'b1;
      blank(4);
      VSYNC = 1'b0;
      blank(VBP_PCLK);
   endtask : send_frame

   // ----------------------------------------
   // Flash, fixed latency in request order
   // ----------------------------------------
   always @(posedge CLK_SYS)
   begin
      cnt     <= cnt + 24'h1;
      pipe[0] <= {FL_RD_EN, fmem[FL_ADDR]};
      pipe[1] <= pipe[0];
      pipe[2] <= pipe[1];
      pipe[3] <= pipe[2];
   end

   assign FL_RVALID = pipe[slow][PIX_W];
   assign FL_RDATA  = FL_RVALID ? pipe[slow][PIX_W-1:0] : (cnt ^ 24'hA5A5A5);
endmodule : bps_partner

// >>> test/testbench.sv
`timescale 1ns/10ps
module testbench
   import bps_pkg::*;
();
   logic             CLK_SYS, RST_B, PCLK, VSYNC, DE, DUAL_PIX, PAT_MODE, PAT_START;
   logic [PIX_W-1:0] PIX_A, PIX_B, FL_RDATA;
   logic [1:0]       BPP_SEL, MA_COLOR, MA_ROW_ADDR;
   logic [4:0]       FL_ADDR;
   logic             FL_RD_EN, FL_RVALID, MA_ROW_WR, MA_PLANE_GO, SEQ_BUSY;
   logic [7:0]       MA_ROW_DATA;
   logic [2:0]       MA_BIT;
   logic [23:0]      lfsr_r = 24'hC;
   logic [31:0]      rows_r;
   logic [1:0]       q_col [$];
   logic [2:0]       q_bit [$];
   logic [31:0]      q_pl  [$];
   int               q_t   [$];
   int               cyc = 0, fails = 0, tests_run = 0;
   logic [1:0]       bpps [0:2] = '{BPP_16, BPP_20, BPP_24};

   bps_sequencer #(.H_PIX(8), .V_LIN(4), .UNIT(2)) i_bps_sequencer
   (
      .CLK_SYS(CLK_SYS), .RST_B(RST_B), .PCLK(PCLK), .VSYNC(VSYNC), .DE(DE), .PIX_A(PIX_A),
      .PIX_B(PIX_B), .DUAL_PIX(DUAL_PIX), .BPP_SEL(BPP_SEL), .PAT_MODE(PAT_MODE),
      .PAT_START(PAT_START), .FL_ADDR(FL_ADDR), .FL_RD_EN(FL_RD_EN), .FL_RDATA(FL_RDATA),
      .FL_RVALID(FL_RVALID), .MA_ROW_DATA(MA_ROW_DATA), .MA_ROW_ADDR(MA_ROW_ADDR),
      .MA_ROW_WR(MA_ROW_WR), .MA_PLANE_GO(MA_PLANE_GO), .MA_COLOR(MA_COLOR), .MA_BIT(MA_BIT),
      .SEQ_BUSY(SEQ_BUSY)
   );

   bps_partner #(.H(8)) i_bps_partner
   (
      .CLK_SYS(CLK_SYS), .PCLK(PCLK), .VSYNC(VSYNC), .DE(DE), .PIX_A(PIX_A), .PIX_B(PIX_B),
      .FL_ADDR(FL_ADDR), .FL_RD_EN(FL_RD_EN), .FL_RDATA(FL_RDATA), .FL_RVALID(FL_RVALID)
   );

   // ----------------------------------------
   // Clocks and plane capture
   // ----------------------------------------
   initial
   begin
      CLK_SYS = 1'b0;
      forever #10 CLK_SYS = ~CLK_SYS;
   end

   initial
   begin
      PCLK = 1'b0;
      #5 PCLK = 1'b1;
      forever #24 PCLK = ~PCLK;
   end

   always @(posedge CLK_SYS)
   begin
      cyc = cyc + 1;
      if (MA_ROW_WR === 1'b1)
         rows_r[{MA_ROW_ADDR, 3'h0} +: 8] = MA_ROW_DATA;
      if (MA_PLANE_GO === 1'b1)
      begin
         q_col.push_back(MA_COLOR);
         q_bit.push_back(MA_BIT);
         q_pl.push_back(rows_r);
         q_t.push_back(cyc);
      end
   end

   // ----------------------------------------
   // Checking helpers
   // ----------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string m);
      tests_run = tests_run + 1;
      if (seen !== exp)
      begin
         fails = fails + 1;
         $display("MISMATCH t=%0t %s seen %h exp %h", $time, m, seen, exp);
      end
   endtask : check

   task give_verdict;
      $display("TB counts: run %0d fails %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : give_verdict

   function automatic int depth(input logic [1:0] bpp, input int c);
      if (bpp == BPP_16)
         return (c == 1) ? 6 : 5;
      if (bpp == BPP_20)
         return (c == 2) ? 6 : 7;
      return 8;
   endfunction : depth

   function automatic logic [31:0] exp_plane(input bit fl, input int c, input int b);
      logic [31:0] p;
      logic [23:0] w;
      for (int a = 0; a < 32; a++)
      begin
         w    = fl ? i_bps_partner.fmem[a] : i_bps_partner.img[a];
         p[a] = w[(2-c)*8+b];
      end
      return p;
   endfunction : exp_plane

   function automatic logic [23:0] lfsr_next(input logic [23:0] v);
      return {v[22:0], v[23] ^ v[22] ^ v[21] ^ v[16]};
   endfunction : lfsr_next

   task automatic fill(input bit fl);
      for (int a = 0; a < 64; a++)
      begin
         lfsr_r = lfsr_next(lfsr_r);
         if (fl)
            i_bps_partner.fmem[a%32] = lfsr_r;
         else
            i_bps_partner.img[a] = lfsr_r;
      end
      if (fl)
         i_bps_partner.fmem[0] = 24'hFFFFFF;
      else
         i_bps_partner.img[31] = 24'h0;
   endtask : fill

   // Expected plane order and contents, and relative hold times at BPP_24
   task automatic check_planes(input bit fl, input logic [1:0] bpp, input int base);
      int n, k, b, pb, d, d0;
      n = depth(bpp, 0) + depth(bpp, 1) + depth(bpp, 2);
      for (int w = 0; w < 20000 && q_col.size() < base + n; w++)
         @(posedge CLK_SYS);
      check(q_col.size() >= base + n, 1, "plane count");
      k = base;
      for (int c = 0; c < 3; c++)
         for (int o = 0; o < 8; o++)
         begin
            b = PLANE_ORDER[o*3 +: 3];
            if (b >= 8 - depth(bpp, c))
            begin
               check(q_col[k], c, "color");
               check(q_bit[k], b, "bit");
               check(q_pl[k], exp_plane(fl, c, b), "plane");
               if (bpp == BPP_24 && o > 0)
               begin
                  d = q_t[k] - q_t[k-1] - (2 << pb);
                  if (o == 1)
                     d0 = d;
                  else
                     check(d, d0, "hold");
               end
               pb = b;
               k  = k + 1;
            end
         end
   endtask : check_planes

   task automatic start_pat(input int lat);
      fill(1);
      i_bps_partner.slow = lat;
      @(posedge CLK_SYS);
      #2;
      PAT_MODE  = 1'b1;
      PAT_START = 1'b1;
      @(posedge CLK_SYS);
      #2;
      PAT_START = 1'b0;
      q_col.delete();
      q_bit.delete();
      q_pl.delete();
      q_t.delete();
   endtask : start_pat

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      RST_B     = 1'b0;
      BPP_SEL   = BPP_24;
      DUAL_PIX  = 1'b0;
      PAT_MODE  = 1'b0;
      PAT_START = 1'b0;
      repeat (6) @(posedge CLK_SYS);
      check({MA_ROW_WR, MA_PLANE_GO, SEQ_BUSY, FL_RD_EN}, 0, "reset");
      #2 RST_B = 1'b1;
      // Pixel side leaves reset only after its three-stage synchroniser settles
      repeat (10) @(posedge CLK_SYS);
      for (int s = 0; s < 3; s++)
      begin
         #2;
         BPP_SEL  = bpps[s];
         DUAL_PIX = (s == 0);
         fill(0);
         q_col.delete();
         q_bit.delete();
         q_pl.delete();
         q_t.delete();
         // Forty pixels: the tail past the array is dropped
         i_bps_partner.send_frame(40, s == 0);
         check_planes(0, bpps[s], 0);
         check(SEQ_BUSY, 1'b0, "idle after blue");
         $display("TB test video %0d done", s);
         @(posedge CLK_SYS);
      end
      start_pat(3);
      check_planes(1, BPP_24, 0);
      fill(0);
      i_bps_partner.send_frame(32, 0);
      check_planes(1, BPP_24, 24);
      check(SEQ_BUSY, 1'b1, "pattern keeps running");
      $display("TB test pattern load done");
      start_pat(0);
      check_planes(1, BPP_24, 0);
      $display("TB test pattern restart done");
      give_verdict;
   end

   initial
   begin
      // Four frames with their back porch plus the plane checks
      #1800000;
      fails = fails + 1;
      give_verdict;
   end
endmodule : testbench
